/* File: verilog/qug_global_ctrl.sv */
// Global configuration and status registers of a four-channel UART device
//
// Notes on behaviour
// - Summary register bit N is one while channel N has an interrupt; upper bits zero.
// - Two locator registers hold a 3-bit source code for each of four channels.
// - Code 1: receive data or line error; data clears below trigger, error on status read.
// - Code 2: receive time-out, held until the receive FIFO is empty.
// - Code 3: transmit holding or shift register empty; clears on interrupt status read.
// - Code 4: modem deltas clear on modem status read; character detects on status read.
// - Counter time-out is code 7, channel 0 only; cleared by counter control read.
// - 16-bit down-counter clocked from crystal or external pin, can interrupt.
// - Control bit 0 enables counter interrupt; a control read clears it except in a time-out cycle.
// - Control bit 1 starts or restarts counting; zero pauses.
// - Control bit 2 zero retriggers periodically, one runs one shot.
// - Control bit 3 zero selects crystal clock, one selects external pin.
// - Control bits 7:4 and the reserved counter register read zero.
// - Counter value is low and high byte registers, both zero after reset.
// - Sampling register bit N selects 8X when one, 16X when zero, for channel N.
// - Writing one to soft reset bit N resets channel N; bit clears itself.
// - Sleep bit N enables sleep; channel sleeps only with no interrupt pending.
// - All four asleep stops the oscillator; receive byte or modem change wakes.
// - Device is fully working 32 crystal clocks after wake-up.
// - Wake-up raises a special interrupt with no source shown, gated by enable.
// - Identification register: upper nibble series, lower nibble channel count.
// - Revision register returns the silicon revision code.
// - Broadcast bit 0 makes channel configuration writes reach all four channels.
`timescale 1ns/10ps
`default_nettype none
`include "qug_consts.svh"
module qug_global_ctrl
  import qug_pkg::*;
#(
  parameter logic [3:0] SERIES_CODE = 4'h5, // Arbitrary value
  parameter logic [7:0] REVISION    = 8'hA0, // Arbitrary value
  parameter int         CHANNELS    = 4
) (
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  // Host register port
  input  wire logic [7:0] addr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       wr_i,
  input  wire logic       rd_i,
  output logic      [7:0] rdata_o,
  // Per-channel interrupt sources from the channel datapaths
  input  wire logic [3:0] rx_ready_i,
  input  wire logic [3:0] rx_line_err_i,
  input  wire logic [3:0] rx_timeout_i,
  input  wire logic [3:0] tx_empty_i,
  input  wire logic [3:0] modem_delta_i,
  input  wire logic [3:0] char_detect_i,
  // Wake events and counter clock pin
  input  wire logic [3:0] rx_byte_i,
  input  wire logic [3:0] modem_change_i,
  input  wire logic       external_count_clock_pin_i,
  // Controls to the channels, sleep status and interrupt outputs
  output logic      [3:0] sampling_8x_o,
  output logic      [3:0] channel_reset_o,
  output logic      [3:0] channel_sleep_o,
  output logic            osc_stop_o,
  output logic            device_ready_o,
  output logic            wake_irq_o,
  output logic            counter_irq_o,
  output logic            broadcast_o,
  output logic            irq_o
);

  // ****************************************
  // Registers and state
  // ****************************************
  logic [7:0]  countdown_control;
  logic [7:0]  countdown_low_byte;
  logic [7:0]  countdown_high_byte;
  logic [3:0]  sampling_rate_select;
  logic [3:0]  channel_sleep_enable;
  logic        broadcast_write_control;
  logic [15:0] count;
  logic        count_hit;
  logic        wake_pend;
  logic [5:0]  warm_cnt;
  qug_sleep_e  sleep_st;
  logic        ext_sync;
  logic        ext_prev;
  logic        tick;
  logic        wr_ctrl;
  logic        rd_ctrl;
  logic [3:0]  chan_pending;
  qug_code_t   codes [4];
  logic        rd_sleep;
  logic        wake_evt;
  logic        warm_done;
  logic [7:0]  loc_low;
  logic [7:0]  loc_high;

  // ****************************************
  // Register strobes
  // ****************************************
  // Strobe decode shared by reads and writes
  function automatic logic hit(input logic [7:0] a, input logic [7:0] target);
    hit = (a == target);
  endfunction

  // Loaded period; both reload points use it so they cannot disagree
  function automatic logic [15:0] period(input logic [7:0] hi, input logic [7:0] lo);
    period = {hi, lo};
  endfunction

  // A control read also clears the counter interrupt, a sleep read the wake flag
  assign wr_ctrl  = wr_i && hit(addr_i, `QUG_ADDR_CNT_CTRL);
  assign rd_ctrl  = rd_i && hit(addr_i, `QUG_ADDR_CNT_CTRL);
  assign rd_sleep = rd_i && hit(addr_i, `QUG_ADDR_SLEEP);

  // ****************************************
  // Interrupt source encoding
  // ****************************************
  // Sources stay asserted until the channel logic clears them on its own register reads
  genvar g;
  generate
    for (g = 0; g < CHANNELS; g++) begin : g_ch
      logic cnt_src;
      assign cnt_src = (g == 0) ? counter_irq_o : 1'b0;
      qug_prio_enc u_enc (
        .rx_i         (rx_ready_i[g] | rx_line_err_i[g]),
        .rx_timeout_i (rx_timeout_i[g]),
        .tx_i         (tx_empty_i[g]),
        .modem_i      (modem_delta_i[g] | char_detect_i[g]),
        .counter_i    (cnt_src),
        .code_o       (codes[g])
      );
      assign chan_pending[g] = (codes[g] != 3'h0);
    end
  endgenerate

  // Locator fields straddle the byte boundary: channel 2 is split across both
  assign loc_low  = {codes[2][1:0], codes[1], codes[0]};
  assign loc_high = {4'h0, codes[3], codes[2][2]};

  // ****************************************
  // Counter clock select
  // ****************************************
  // Pin is asynchronous, so only the second flop's output is used
  qug_sync #(.WIDTH(1)) u_ext_sync (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .d_i     (external_count_clock_pin_i),
    .q_o     (ext_sync)
  );

  // Edge of the synchronised pin; pin rate limited to under half of clk
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ext_prev <= 1'b0;
    end else begin
      ext_prev <= ext_sync;
    end
  end

  // Crystal clock counts every cycle, pin clock on rising edges
  assign tick = countdown_control[`QUG_CTRL_EXT_CLK] ? (ext_sync & ~ext_prev) : 1'b1;

  // ****************************************
  // Counter control and value registers
  // ****************************************
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      countdown_control   <= `QUG_RESET_BYTE;
      countdown_low_byte  <= `QUG_RESET_BYTE;
      countdown_high_byte <= `QUG_RESET_BYTE;
    end else begin
      // A control write wins over the one-shot stop of the same cycle
      if (wr_ctrl) begin
        countdown_control <= {4'h0, wdata_i[3:0]};
      end else if (count_hit && countdown_control[`QUG_CTRL_ONE_SHOT]) begin
        countdown_control[`QUG_CTRL_START] <= 1'b0;
      end
      if (wr_i && hit(addr_i, `QUG_ADDR_CNT_LOW)) begin
        countdown_low_byte <= wdata_i;
      end
      if (wr_i && hit(addr_i, `QUG_ADDR_CNT_HIGH)) begin
        countdown_high_byte <= wdata_i;
      end
    end
  end

  // Down-counter; a start write reloads so restart begins from the full value
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      count     <= 16'h0000;
      count_hit <= 1'b0;
    end else begin
      count_hit <= 1'b0;
      if (wr_ctrl && wdata_i[`QUG_CTRL_START]) begin
        count <= period(countdown_high_byte, countdown_low_byte);
      end else if (countdown_control[`QUG_CTRL_START] && tick) begin
        // A loaded zero behaves as one, so the counter never wraps
        if (count <= 16'h0001) begin
          count_hit <= 1'b1;
          count     <= period(countdown_high_byte, countdown_low_byte);
        end else begin
          count <= count - 16'h0001;
        end
      end
    end
  end

  // Sticky counter interrupt; a time-out in the read cycle wins
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      counter_irq_o <= 1'b0;
    end else if (count_hit && countdown_control[`QUG_CTRL_INT_EN]) begin
      counter_irq_o <= 1'b1;
    end else if (rd_ctrl || !countdown_control[`QUG_CTRL_INT_EN]) begin
      counter_irq_o <= 1'b0;
    end
  end

  // ****************************************
  // Channel controls
  // ****************************************
  // Sampling rate per channel; upper bits are not stored
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sampling_rate_select <= 4'h0;
    end else if (wr_i && hit(addr_i, `QUG_ADDR_SAMPLING)) begin
      sampling_rate_select <= wdata_i[3:0];
    end
  end

  // Sleep enables; only the channel bits are stored
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      channel_sleep_enable <= 4'h0;
    end else if (wr_i && hit(addr_i, `QUG_ADDR_SLEEP)) begin
      channel_sleep_enable <= wdata_i[3:0];
    end
  end

  // Broadcast bit; bits 7:1 are reserved and dropped
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      broadcast_write_control <= 1'b0;
    end else if (wr_i && hit(addr_i, `QUG_ADDR_BROADCAST)) begin
      broadcast_write_control <= wdata_i[0];
    end
  end

  // One-cycle reset pulse per channel, self-clearing
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      channel_reset_o <= 4'h0;
    end else if (wr_i && hit(addr_i, `QUG_ADDR_SOFT_RESET)) begin
      channel_reset_o <= wdata_i[3:0];
    end else begin
      channel_reset_o <= 4'h0;
    end
  end

  // Sleep request is masked while the channel still has work pending
  assign sampling_8x_o   = sampling_rate_select;
  assign broadcast_o     = broadcast_write_control;
  assign channel_sleep_o = channel_sleep_enable & ~chan_pending;

  // ****************************************
  // Global sleep and wake-up
  // ****************************************
  // Any channel's receive byte or modem change ends global sleep
  assign wake_evt  = (|rx_byte_i) | (|modem_change_i);
  // Last warm-up cycle; shared by the state machine and the wake flag
  assign warm_done = (sleep_st == QUG_WARMING) && (warm_cnt == 6'(`QUG_WAKE_CYCLES - 1));

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sleep_st <= QUG_AWAKE;
      warm_cnt <= 6'h00;
    end else begin
      case (sleep_st)
        QUG_AWAKE: begin
          if (&channel_sleep_o) begin
            sleep_st <= QUG_ASLEEP;
          end
        end
        QUG_ASLEEP: begin
          if (wake_evt) begin
            sleep_st <= QUG_WARMING;
            warm_cnt <= 6'h00;
          end
        end
        QUG_WARMING: begin
          if (warm_done) begin
            sleep_st <= QUG_AWAKE;
          end else begin
            warm_cnt <= warm_cnt + 6'h01;
          end
        end
        default: begin
          sleep_st <= QUG_AWAKE;
        end
      endcase
    end
  end

  // Special wake interrupt; cleared by a read of the sleep register
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wake_pend <= 1'b0;
    end else if (warm_done) begin
      wake_pend <= 1'b1;
    end else if (rd_sleep) begin
      wake_pend <= 1'b0;
    end
  end

  // Oscillator stop and ready are plain decodes of the sleep state
  assign osc_stop_o     = (sleep_st == QUG_ASLEEP);
  assign device_ready_o = (sleep_st == QUG_AWAKE);
  assign wake_irq_o     = wake_pend & (|channel_sleep_enable);
  assign irq_o          = (|chan_pending) | wake_irq_o;

  // ****************************************
  // Read data
  // ****************************************
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_o <= 8'h00;
    end else if (rd_i) begin
      // Unmapped, reserved and write-only places read zero
      case (addr_i)
        `QUG_ADDR_SUMMARY:   rdata_o <= {4'h0, chan_pending};
        `QUG_ADDR_LOC_LOW:   rdata_o <= loc_low;
        `QUG_ADDR_LOC_HIGH:  rdata_o <= loc_high;
        `QUG_ADDR_CNT_CTRL:  rdata_o <= {4'h0, countdown_control[3:0]};
        `QUG_ADDR_CNT_LOW:   rdata_o <= countdown_low_byte;
        `QUG_ADDR_CNT_HIGH:  rdata_o <= countdown_high_byte;
        `QUG_ADDR_SAMPLING:  rdata_o <= {4'h0, sampling_rate_select};
        `QUG_ADDR_SLEEP:     rdata_o <= {4'h0, channel_sleep_enable};
        `QUG_ADDR_REVISION:  rdata_o <= REVISION;
        `QUG_ADDR_IDENT:     rdata_o <= {SERIES_CODE, 4'(CHANNELS)};
        `QUG_ADDR_BROADCAST: rdata_o <= {7'h00, broadcast_write_control};
        default:             rdata_o <= 8'h00;
      endcase
    end
  end

endmodule
`default_nettype wire

/* File: pkg/qug_consts.svh */
// Offsets, field positions, reset values and timing counts of the global control block
`ifndef QUG_CONSTS_SVH
`define QUG_CONSTS_SVH
`define QUG_ADDR_SUMMARY     8'h80
`define QUG_ADDR_LOC_LOW     8'h81
`define QUG_ADDR_LOC_HIGH    8'h82
`define QUG_ADDR_LOC_SPARE   8'h83
`define QUG_ADDR_CNT_CTRL    8'h84
`define QUG_ADDR_CNT_RSVD    8'h85
`define QUG_ADDR_CNT_LOW     8'h86
`define QUG_ADDR_CNT_HIGH    8'h87
`define QUG_ADDR_SAMPLING    8'h88
`define QUG_ADDR_RSVD_A      8'h89
`define QUG_ADDR_SOFT_RESET  8'h8A
`define QUG_ADDR_SLEEP       8'h8B
`define QUG_ADDR_REVISION    8'h8C
`define QUG_ADDR_IDENT       8'h8D
`define QUG_ADDR_BROADCAST   8'h8E
`define QUG_CTRL_INT_EN      0
`define QUG_CTRL_START       1
`define QUG_CTRL_ONE_SHOT    2
`define QUG_CTRL_EXT_CLK     3
`define QUG_RESET_BYTE       8'h00
`define QUG_WAKE_CYCLES      32
`endif

/* File: pkg/qug_pkg.sv */
// Types shared by the global control block
`default_nettype none
package qug_pkg;
  typedef logic [2:0] qug_code_t;
  typedef enum logic [1:0] {
    QUG_AWAKE    = 2'b00,
    QUG_ASLEEP   = 2'b01,
    QUG_WARMING  = 2'b10
  } qug_sleep_e;
endpackage
`default_nettype wire

/* File: verilog/qug_prio_enc.sv */
// Per-channel interrupt source priority encoder
`timescale 1ns/10ps
`default_nettype none
module qug_prio_enc
  import qug_pkg::*;
(
  input  wire logic      rx_i,
  input  wire logic      rx_timeout_i,
  input  wire logic      tx_i,
  input  wire logic      modem_i,
  input  wire logic      counter_i,
  output qug_code_t      code_o
);
  // Lowest priority number wins
  always_comb begin
    if (rx_i) begin
      code_o = 3'h1;
    end else if (rx_timeout_i) begin
      code_o = 3'h2;
    end else if (tx_i) begin
      code_o = 3'h3;
    end else if (modem_i) begin
      code_o = 3'h4;
    end else if (counter_i) begin
      code_o = 3'h7;
    end else begin
      code_o = 3'h0;
    end
  end
endmodule
`default_nettype wire

/* File: verilog/qug_sync.sv */
// Two-flop synchroniser for pin inputs
`timescale 1ns/10ps
`default_nettype none
module qug_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_i,
  input  wire logic             rst_n_i,
  input  wire logic [WIDTH-1:0] d_i,
  output logic      [WIDTH-1:0] q_o
);
  logic [WIDTH-1:0] meta;
  // First stage feeds only the second
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta <= '0;
      q_o  <= '0;
    end else begin
      meta <= d_i;
      q_o  <= meta;
    end
  end
endmodule
`default_nettype wire

/* File: dv/qug_global_ctrl_props.sv */
// Port-level assertions of the global control block, bound to its top
`timescale 1ns/10ps
`default_nettype none
`include "qug_consts.svh"
module qug_global_ctrl_props (
  input wire logic       clk_i,
  input wire logic       rst_n_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic       wr_i,
  input wire logic       rd_i,
  input wire logic [3:0] rx_ready_i,
  input wire logic [3:0] rx_timeout_i,
  input wire logic [3:0] tx_empty_i,
  input wire logic [3:0] rx_byte_i,
  input wire logic [3:0] sampling_8x_o,
  input wire logic [3:0] channel_reset_o,
  input wire logic [3:0] channel_sleep_o,
  input wire logic       osc_stop_o,
  input wire logic       device_ready_o,
  input wire logic       counter_irq_o,
  input wire logic       broadcast_o,
  input wire logic       irq_o
);
  // ****
  // Checks
  // ****
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  logic [3:0] src;
  logic [5:0] warm;
  // Only a subset of sources, enough for the implications below
  assign src = rx_ready_i | rx_timeout_i | tx_empty_i;
  // Warm-up length, saturating so a stuck wake never wraps
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) warm <= 6'h00;
    else if (osc_stop_o) warm <= 6'h00;
    else if (!device_ready_o && warm != 6'h3F) warm <= warm + 6'h01;
  end
  chk_reset_pulse: assert property (wr_i && addr_i == `QUG_ADDR_SOFT_RESET
    |=> channel_reset_o == $past(wdata_i[3:0])) else $error("soft reset pulse wrong");
  chk_reset_self: assert property (!(wr_i && addr_i == `QUG_ADDR_SOFT_RESET)
    |=> channel_reset_o == 4'h0) else $error("soft reset bit stuck");
  chk_rate_write: assert property (wr_i && addr_i == `QUG_ADDR_SAMPLING
    |=> sampling_8x_o == $past(wdata_i[3:0])) else $error("sampling select wrong");
  chk_bcast_write: assert property (wr_i && addr_i == `QUG_ADDR_BROADCAST
    |=> broadcast_o == $past(wdata_i[0])) else $error("broadcast bit wrong");
  chk_sleep_pending: assert property ((src & channel_sleep_o) == 4'h0)
    else $error("channel asleep with pending source");
  chk_irq_summary: assert property (|src |-> irq_o)
    else $error("pending source without interrupt");
  chk_cnt_clear: assert property (counter_irq_o && rd_i
    && addr_i == `QUG_ADDR_CNT_CTRL |=> !counter_irq_o) else $error("counter irq not cleared");
  chk_osc_ready: assert property (osc_stop_o |-> !device_ready_o)
    else $error("ready while oscillator stopped");
  chk_wake_event: assert property (osc_stop_o && |rx_byte_i |-> ##[1:4] !osc_stop_o)
    else $error("no wake on receive byte");
  chk_warm_time: assert property ($rose(device_ready_o)
    |-> warm >= 6'h1E && warm <= 6'h22) else $error("warm-up length wrong");
  cover property (osc_stop_o ##[1:60] device_ready_o);
  cover property ($rose(counter_irq_o));
  cover property (|channel_reset_o);
endmodule
bind qug_global_ctrl qug_global_ctrl_props i_props (.clk_i(clk_i), .rst_n_i(rst_n_i),
  .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rx_ready_i(rx_ready_i),
  .rx_timeout_i(rx_timeout_i), .tx_empty_i(tx_empty_i), .rx_byte_i(rx_byte_i),
  .sampling_8x_o(sampling_8x_o), .channel_reset_o(channel_reset_o),
  .channel_sleep_o(channel_sleep_o), .osc_stop_o(osc_stop_o),
  .device_ready_o(device_ready_o), .counter_irq_o(counter_irq_o),
  .broadcast_o(broadcast_o), .irq_o(irq_o));
`default_nettype wire

/* File: dv/qug_host_model.sv */
// Host processor model on the 8-bit register port
`timescale 1ns/10ps
`default_nettype none
module qug_host_model (
  input  wire logic       clk_i,
  input  wire logic [7:0] rdata_i,
  output logic      [7:0] addr_o,
  output logic      [7:0] wdata_o,
  output logic            wr_o,
  output logic            rd_o
);
  // ****
  // Bus cycles
  // ****
  initial begin
    addr_o = 8'h00;
    wdata_o = 8'h00;
    wr_o = 1'b0;
    rd_o = 1'b0;
  end
  // Idle bus shows the inverse, so a stale value never looks valid
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_i);
    addr_o = a;
    wdata_o = d;
    wr_o = 1'b1;
    @(negedge clk_i);
    wr_o = 1'b0;
    addr_o = ~a;
    wdata_o = ~d;
  endtask
  // Read data is registered, so it is taken a cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk_i);
    addr_o = a;
    rd_o = 1'b1;
    @(negedge clk_i);
    rd_o = 1'b0;
    addr_o = ~a;
    @(negedge clk_i);
    d = rdata_i;
  endtask
endmodule
`default_nettype wire

/* File: dv/qug_global_ctrl_bench.sv */
// Self-checking bench of the global control block
`timescale 1ns/10ps
`default_nettype none
`include "qug_consts.svh"
module qug_global_ctrl_bench;
  localparam logic [3:0] SER = 4'h5;  // Arbitrary value
  localparam logic [7:0] REV = 8'hA0; // Arbitrary value
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [7:0] addr, wdata, rdata, d;
  logic wr, rd, ext_clk, osc_stop, device_ready, wake_irq, counter_irq, broadcast, irq;
  logic [3:0] rx_ready, rx_line_err, rx_timeout, tx_empty, modem_delta, char_detect;
  logic [3:0] rx_byte, modem_change, sampling_8x, channel_reset, channel_sleep;
  int n_fail = 0;
  int cmp_count = 0;
  int n;
  always #12.5 clk_i = ~clk_i;
  qug_global_ctrl #(.SERIES_CODE(SER), .REVISION(REV)) i_dut (.clk_i(clk_i),
    .rst_n_i(rst_n_i), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
    .rdata_o(rdata), .rx_ready_i(rx_ready), .rx_line_err_i(rx_line_err),
    .rx_timeout_i(rx_timeout), .tx_empty_i(tx_empty), .modem_delta_i(modem_delta),
    .char_detect_i(char_detect), .rx_byte_i(rx_byte), .modem_change_i(modem_change),
    .external_count_clock_pin_i(ext_clk), .sampling_8x_o(sampling_8x),
    .channel_reset_o(channel_reset), .channel_sleep_o(channel_sleep), .osc_stop_o(osc_stop),
    .device_ready_o(device_ready), .wake_irq_o(wake_irq), .counter_irq_o(counter_irq),
    .broadcast_o(broadcast), .irq_o(irq));
  qug_host_model i_host (.clk_i(clk_i), .rdata_i(rdata), .addr_o(addr), .wdata_o(wdata),
    .wr_o(wr), .rd_o(rd));
  // ****
  // Helpers
  // ****
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    i_host.rd(a, d);
    chk(d, exp);
  endtask
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // A wait that ran out is a hang: report at once
  task automatic bound(input int cnt, input int lim);
    if (cnt >= lim) begin
      n_fail++;
      complete_run();
    end
  endtask
  // ****
  // Scenarios
  // ****
  // Reset values; revision, identification, two reserved places and one unmapped place ignore writes
  task automatic t_reset_vals();
    logic [7:0] a;
    for (int i = 0; i < 16; i++) begin
      a = 8'h80 + 8'(i);
      if (a inside {8'h85, 8'h89, 8'h8C, 8'h8D, 8'h8F}) i_host.wr(a, 8'hFF);
      rchk(a, a == 8'h8C ? REV : a == 8'h8D ? {SER, 4'h4} : 8'h00);
    end
  endtask
  // Codes 1 to 4, one per channel, then two each on channels 0, 1 and 3 to test priority
  task automatic t_locator();
    rx_ready = 4'h1;
    rx_timeout = 4'h2;
    tx_empty = 4'h4;
    modem_delta = 4'h8;
    rchk(`QUG_ADDR_SUMMARY, 8'h0F);
    chk({7'h0, irq}, 8'h01);
    rchk(`QUG_ADDR_LOC_LOW, 8'hD1);
    rchk(`QUG_ADDR_LOC_HIGH, 8'h08);
    rx_ready = 4'h0;
    rx_line_err = 4'h1;
    rx_timeout = 4'h8;
    tx_empty = 4'hA;
    modem_delta = 4'h2;
    char_detect = 4'h5;
    rchk(`QUG_ADDR_LOC_LOW, 8'h19);
    rchk(`QUG_ADDR_LOC_HIGH, 8'h05);
    {rx_line_err, rx_timeout, tx_empty, modem_delta, char_detect} = 20'h00000;
  endtask
  task automatic t_config();
    i_host.wr(`QUG_ADDR_SAMPLING, 8'h0A);
    chk({7'h0, irq}, 8'h00);
    chk({4'h0, sampling_8x}, 8'h0A);
    rchk(`QUG_ADDR_SAMPLING, 8'h0A);
    i_host.wr(`QUG_ADDR_SOFT_RESET, 8'h05);
    chk({4'h0, channel_reset}, 8'h05);
    @(negedge clk_i);
    chk({4'h0, channel_reset}, 8'h00);
    i_host.wr(`QUG_ADDR_BROADCAST, 8'hFF);
    chk({7'h0, broadcast}, 8'h01);
    rchk(`QUG_ADDR_BROADCAST, 8'h01);
    i_host.wr(`QUG_ADDR_BROADCAST, 8'h00);
  endtask
  // Period of 20 crystal ticks: periodic, then one shot, then masked
  task automatic t_counter();
    i_host.wr(`QUG_ADDR_CNT_LOW, 8'h14);
    i_host.wr(`QUG_ADDR_CNT_HIGH, 8'h00);
    i_host.wr(`QUG_ADDR_CNT_CTRL, 8'hF3);
    for (n = 0; n < 60 && !counter_irq; n++) @(negedge clk_i);
    chk(8'(n), 8'h15);
    rchk(`QUG_ADDR_LOC_LOW, 8'h07);
    rchk(`QUG_ADDR_CNT_CTRL, 8'h03);
    chk({7'h0, counter_irq}, 8'h00);
    for (n = 0; n < 25 && !counter_irq; n++) @(negedge clk_i);
    bound(n, 25);
    i_host.wr(`QUG_ADDR_CNT_CTRL, 8'h07);
    rchk(`QUG_ADDR_CNT_CTRL, 8'h07);
    for (n = 0; n < 30 && !counter_irq; n++) @(negedge clk_i);
    bound(n, 30);
    rchk(`QUG_ADDR_CNT_CTRL, 8'h05);
    repeat (30) @(negedge clk_i);
    chk({7'h0, counter_irq}, 8'h00);
    i_host.wr(`QUG_ADDR_CNT_CTRL, 8'h02);
    repeat (30) @(negedge clk_i);
    chk({7'h0, counter_irq}, 8'h00);
  endtask
  // External pin clock: nothing counts until the pin toggles
  task automatic t_ext();
    i_host.wr(`QUG_ADDR_CNT_LOW, 8'h03);
    i_host.wr(`QUG_ADDR_CNT_CTRL, 8'h0B);
    repeat (40) @(negedge clk_i);
    chk({7'h0, counter_irq}, 8'h00);
    repeat (5) begin
      ext_clk = 1'b1;
      repeat (3) @(negedge clk_i);
      ext_clk = 1'b0;
      repeat (3) @(negedge clk_i);
    end
    chk({7'h0, counter_irq}, 8'h01);
    i_host.wr(`QUG_ADDR_CNT_CTRL, 8'h00);
    rchk(`QUG_ADDR_CNT_CTRL, 8'h00);
  endtask
  // Pending source blocks sleep; receive byte wakes after warm-up
  task automatic t_sleep();
    rx_ready = 4'h1;
    i_host.wr(`QUG_ADDR_SLEEP, 8'h0F);
    chk({3'h0, osc_stop, channel_sleep}, 8'h0E);
    rx_ready = 4'h0;
    repeat (2) @(negedge clk_i);
    chk({6'h0, osc_stop, device_ready}, 8'h02);
    rx_byte = 4'h4;
    rx_ready = 4'h4;
    @(negedge clk_i);
    rx_byte = 4'h0;
    for (n = 0; n < 60 && !device_ready; n++) @(negedge clk_i);
    bound(n, 60);
    chk(8'(n > 28 && n < 36), 8'h01);
    @(negedge clk_i);
    chk({7'h0, wake_irq}, 8'h01);
    rchk(`QUG_ADDR_SLEEP, 8'h0F);
    chk({7'h0, wake_irq}, 8'h00);
    rx_ready = 4'h0;
    for (n = 0; n < 4 && !osc_stop; n++) @(negedge clk_i);
    chk({7'h0, osc_stop}, 8'h01);
    modem_change = 4'h8;
    @(negedge clk_i);
    modem_change = 4'h0;
    chk({6'h0, osc_stop, device_ready}, 8'h00);
    i_host.wr(`QUG_ADDR_SLEEP, 8'h00);
  endtask
  // ****
  // Main sequence
  // ****
  initial begin
    {rx_ready, rx_line_err, rx_timeout, tx_empty, modem_delta, char_detect} = 24'h000000;
    {rx_byte, modem_change, ext_clk} = 9'h000;
    repeat (8) @(negedge clk_i);
    rst_n_i = 1'b1;
    t_reset_vals();
    t_locator();
    t_config();
    t_counter();
    t_ext();
    t_sleep();
    complete_run();
  end
endmodule
`default_nettype wire
